// ### bench/scac_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "scac_defs.svh"
module scac_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic tx_request,
   input wire logic dma_tx_write,
   input wire logic rx_request,
   input wire logic dma_rx_read,
   input wire logic [7:0] rx_holding_data
);
   logic acc, mapped, wr_ctrl, wr_stat;
   // =====
   // Access decode
   assign acc = psel && penable;
   assign mapped = paddr inside {{6'h00, `SCAC_IDX_MODE, 2'h0}, {6'h00, `SCAC_IDX_CTRL, 2'h0},
      {6'h00, `SCAC_IDX_TXHOLD, 2'h0}, {6'h00, `SCAC_IDX_STATUS, 2'h0}, {6'h00, `SCAC_IDX_RXHOLD, 2'h0},
      {6'h00, `SCAC_IDX_DIVISOR, 2'h0}};
   assign wr_ctrl = acc && pwrite && paddr == {6'h00, `SCAC_IDX_CTRL, 2'h0};
   assign wr_stat = acc && pwrite && paddr == {6'h00, `SCAC_IDX_STATUS, 2'h0};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====
   // Properties
   property p_width; prdata[31:8] == 24'h000000; endproperty
   a_width: assert property (p_width) else $error("upper read bits set");
   property p_slverr; pslverr == (acc && !mapped); endproperty
   a_slverr: assert property (p_slverr) else $error("slave error wrong");
   property p_txq_dma; dma_tx_write |=> !tx_request; endproperty
   a_txq_dma: assert property (p_txq_dma) else $error("tx request after load");
   property p_txq_off; wr_ctrl && !pwdata[5] |=> !tx_request; endproperty
   a_txq_off: assert property (p_txq_off) else $error("tx request while off");
   property p_rxq_dma; dma_rx_read && rx_request |=> !rx_request; endproperty
   a_rxq_dma: assert property (p_rxq_dma) else $error("rx full kept after read");
   property p_rxq_keep; rx_request && !dma_rx_read && !wr_stat |=> rx_request; endproperty
   a_rxq_keep: assert property (p_rxq_keep) else $error("rx full lost");
   property p_ones; wr_stat && pwdata[6] && rx_request && !dma_rx_read |=> rx_request; endproperty
   a_ones: assert property (p_ones) else $error("write of one cleared flag");
   property p_rxdata; $changed(rx_holding_data) |-> $rose(rx_request); endproperty
   a_rxdata: assert property (p_rxdata) else $error("rx data changed while full");
endmodule : scac_checker
bind scac_top scac_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
   .tx_request(tx_request), .dma_tx_write(dma_tx_write), .rx_request(rx_request),
   .dma_rx_read(dma_rx_read), .rx_holding_data(rx_holding_data));
`default_nettype wire

// ### bench/scac_line_model.sv
`timescale 1ns/10ps
`default_nettype none
module scac_line_model (
   input wire logic pclk,
   input wire logic txd,
   output logic rxd,
   input wire logic seven,
   input wire logic par_on,
   input wire logic [7:0] bit_cyc
);
   logic [72:0] fq[$];
   initial rxd = 1'b1;
   // Decode frames: start time, error flag, byte
   always begin : decode
      logic [7:0] b;
      logic p;
      longint t;
      @(negedge txd);
      t = $time;
      b = 8'h00;
      repeat (bit_cyc / 2) @(posedge pclk);
      p = txd;
      for (int n = 0; n < 8 - seven; n++) begin
         repeat (bit_cyc) @(posedge pclk);
         b[n] = txd;
      end
      if (par_on) begin
         repeat (bit_cyc) @(posedge pclk);
         p = p | ^b ^ txd;
      end
      repeat (bit_cyc) @(posedge pclk);
      fq.push_back({t, p | ~txd, b});
   end
   // Drive one bit time
   task automatic put(input logic v);
      rxd <= v;
      repeat (bit_cyc) @(posedge pclk);
   endtask : put
   // Send a frame, optionally a second stop bit or bad parity
   task automatic send(input logic [7:0] b, input logic two, input logic bad);
      @(posedge pclk);
      put(1'b0);
      for (int n = 0; n < 8 - seven; n++) put(b[n]);
      if (par_on) put(^(b & {~seven, 7'h7F}) ^ bad);
      put(1'b1);
      if (two) put(1'b1);
   endtask : send
endmodule : scac_line_model
`default_nettype wire

// ### bench/scac_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "scac_defs.svh"
module scac_top_tb_top;
   localparam logic [23:0] r_mode = `SCAC_IDX_MODE, r_ctrl = `SCAC_IDX_CTRL, r_txh = `SCAC_IDX_TXHOLD;
   localparam logic [23:0] r_stat = `SCAC_IDX_STATUS;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tmr = 0, dtw = 0, drr = 0;
   logic rxd, txd, pready, pslverr, txq, rxq, err;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic [7:0] dtd = 0, rxh, b, mk, bc = 8'h10;
   logic [2:0] md = 0;
   logic [72:0] f0, f1;
   int n_mismatch = 0, total_checks = 0, cyc = 0, seed = 79, i, d, len;
   // =====
   // Clock, timer input and hang guard
   always #5 pclk = ~pclk;
   always @(posedge pclk) tmr <= ~tmr;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   scac_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
      .timer_clock_input(tmr), .tx_request(txq), .dma_tx_write(dtw), .dma_tx_data(dtd), .rx_request(rxq),
      .dma_rx_read(drr), .rx_holding_data(rxh));
   scac_line_model line (.pclk(pclk), .txd(txd), .rxd(rxd), .seven(md[2]), .par_on(md[1]), .bit_cyc(bc));
   // =====
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s: %h vs %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [23:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {6'h00, idx, 2'h0};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic clr(input logic [7:0] m);
      apb(1'b0, r_stat, 8'h00);
      apb(1'b1, r_stat, m);
   endtask : clr
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   // =====
   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, r_stat, 8'h00);
      check(rd & 32'hF8, 32'h80, "status reset");
      apb(1'b0, 24'hFFF6FF, 8'h00);
      check(err, 1, "unmapped error");
      check(rd, 0, "unmapped data");
      apb(1'b1, `SCAC_IDX_DIVISOR, 8'h00);
      apb(1'b1, r_ctrl, 8'h30);
      $display("reset test done");
      for (i = 0; i < 6; i++) begin
         md = 3'($random(seed));
         b = 8'($random(seed));
         mk = md[2] ? 8'h7F : 8'hFF;
         if (i == 5) begin
            bc = 8'h20;
            apb(1'b1, r_ctrl, {7'h19, b[0]});
         end
         apb(1'b1, r_mode, {1'b0, md[2:1], 1'b0, md[0], 3'h0});
         apb(1'b1, r_txh, b);
         apb(1'b0, r_txh, 8'h00);
         check(rd, b, "tx hold");
         clr(8'h7F);
         // Let the clear land, then wait for the shifter to take the byte
         @(posedge pclk);
         wait (txq === 1'b1);
         @(posedge pclk);
         dtw <= 1'b1;
         dtd <= ~b;
         @(posedge pclk);
         dtw <= 1'b0;
         wait (line.fq.size() > 1);
         f0 = line.fq.pop_front();
         f1 = line.fq.pop_front();
         check(f0[7:0], b & mk, "tx byte");
         check(f1[7:0], ~b & mk, "dma byte");
         check(f0[8] | f1[8], 0, "tx frame bits");
         d = int'((f1[72:9] - f0[72:9]) / 10);
         len = (10 - md[2] + md[1] + md[0]) * bc;
         check(d > len - 3 && d < len + 3, 1, "frame length");
         $display("tx format %0d done", i);
      end
      bc = 8'h10;
      md = 3'b001;
      apb(1'b1, r_ctrl, 8'h30);
      apb(1'b1, r_mode, 8'h08);
      fork
         begin
            line.send(8'hA5, 1'b0, 1'b0);
            line.send(8'h3C, 1'b1, 1'b0);
         end
         begin
            wait (rxq === 1'b1);
            @(negedge pclk);
            check(rxh, 8'hA5, "rx first");
            @(posedge pclk) drr <= 1'b1;
            @(posedge pclk) drr <= 1'b0;
         end
      join
      @(negedge pclk);
      check({rxq, rxh}, 9'h13C, "rx second");
      line.send(8'h5A, 1'b1, 1'b0);
      check(rxh, 8'h3C, "overrun drop");
      apb(1'b1, r_stat, 8'hFF);
      apb(1'b1, r_ctrl, 8'h20);
      apb(1'b1, r_stat, 8'h00);
      apb(1'b0, r_stat, 8'h00);
      check(rd[6:5], 2'b11, "flags kept");
      apb(1'b1, r_stat, 8'h9F);
      apb(1'b0, r_stat, 8'h00);
      check(rd[6:5], 2'b00, "flags cleared");
      line.send(8'h11, 1'b1, 1'b0);
      check(rxq, 0, "rx disabled");
      md = 3'b011;
      apb(1'b1, r_ctrl, 8'h30);
      apb(1'b1, r_mode, 8'h28);
      line.send(8'h77, 1'b1, 1'b1);
      apb(1'b0, r_stat, 8'h00);
      check({rxq, rd[3]}, 2'b01, "bad parity");
      $display("rx test done");
      apb(1'b1, r_txh, 8'h01);
      clr(8'h7F);
      @(posedge pclk);
      wait (txq === 1'b1);
      apb(1'b1, r_txh, 8'h02);
      clr(8'h7F);
      apb(1'b1, r_ctrl, 8'h10);
      apb(1'b0, r_stat, 8'h00);
      check(rd[7], 1, "empty on disable");
      check(txd, 1, "tx idle");
      $display("tx disable test done");
      wrap_up();
   end
endmodule : scac_top_tb_top
`default_nettype wire

// ### verilog/scac_baud.sv
`timescale 1ns/10ps
`default_nettype none
module scac_baud import scac_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ext_sel,
   input wire logic [7:0] divisor,
   input wire logic timer_clock_input,
   output logic tick
);
   logic [7:0] div_cnt;
   logic ext_prev;

   // Divider for the internal rate generator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 8'h00;
      end else if (div_cnt >= divisor) begin
         div_cnt <= 8'h00;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end

   // Previous level of the timer clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= timer_clock_input;
      end
   end

   // One tick per sample period from the chosen source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick <= 1'b0;
      end else if (ext_sel) begin
         tick <= timer_clock_input & ~ext_prev;
      end else begin
         tick <= (div_cnt >= divisor);
      end
   end
endmodule : scac_baud
`default_nettype wire

// ### verilog/scac_defs.svh
`ifndef SCAC_DEFS_SVH
`define SCAC_DEFS_SVH
// ==========================================
// Register indices, byte address is index * 4
`define SCAC_IDX_MODE 24'hFFF600
`define SCAC_IDX_CTRL 24'hFFF602
`define SCAC_IDX_TXHOLD 24'hFFF603
`define SCAC_IDX_STATUS 24'hFFF604
`define SCAC_IDX_RXHOLD 24'hFFF605
`define SCAC_IDX_DIVISOR 24'hFFF610
// ==========================================
// Field positions
`define SCAC_MODE_WLEN 6
`define SCAC_MODE_PAR 5
`define SCAC_MODE_STOP 3
`define SCAC_CTRL_TE 5
`define SCAC_CTRL_RE 4
`define SCAC_CTRL_CKS_HI 1
`define SCAC_ST_TX_BUFFER_EMPTY 7
`define SCAC_ST_RX_BUFFER_FULL 6
`define SCAC_ST_OVERRUN_FLAG 5
`define SCAC_ST_FER 4
`define SCAC_ST_PER 3
`define SCAC_ST_TEND 2
// ==========================================
// Reset values
`define SCAC_MODE_RST 8'h00
`define SCAC_CTRL_RST 8'h00
`define SCAC_TXHOLD_RST 8'h00
`define SCAC_DIV_RST 8'h35
// ==========================================
// Timing counts, sixteen ticks per bit
`define SCAC_TICK_LAST 4'hF
`define SCAC_TICK_MID 4'h7
`define SCAC_BIT_LAST_8 3'h7
`define SCAC_BIT_LAST_7 3'h6
`endif

// ### verilog/scac_pkg.sv
`include "scac_defs.svh"
package scac_pkg;
   typedef enum logic [2:0] {SCAC_TX_IDLE = 3'b000, SCAC_TX_START = 3'b001, SCAC_TX_DATA = 3'b010,
      SCAC_TX_PARITY = 3'b011, SCAC_TX_STOP1 = 3'b100, SCAC_TX_STOP2 = 3'b101} scac_tx_state_t;
   typedef enum logic [2:0] {SCAC_RX_IDLE = 3'b000, SCAC_RX_START = 3'b001, SCAC_RX_DATA = 3'b010,
      SCAC_RX_PARITY = 3'b011, SCAC_RX_STOP = 3'b100} scac_rx_state_t;

   // Index of the last data bit for the word length
   function automatic logic [2:0] scac_last_bit(input logic seven);
      scac_last_bit = seven ? `SCAC_BIT_LAST_7 : `SCAC_BIT_LAST_8;
   endfunction : scac_last_bit
endpackage : scac_pkg

// ### verilog/scac_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "scac_defs.svh"
module scac_top import scac_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd,
   output logic txd,
   input wire logic timer_clock_input,
   output logic tx_request,
   input wire logic dma_tx_write,
   input wire logic [7:0] dma_tx_data,
   output logic rx_request,
   input wire logic dma_rx_read,
   output logic [7:0] rx_holding_data
);
   // ==========================================
   // Declarations
   logic [7:0] serial_mode;
   logic [7:0] serial_control;
   logic [7:0] tx_holding_reg;
   logic [7:0] rx_holding_reg;
   logic [7:0] divisor;
   logic tx_buffer_empty;
   logic rx_buffer_full;
   logic overrun_flag;
   logic frame_err_flag;
   logic parity_err_flag;
   logic [4:0] seen_one;
   logic [7:0] status_value;
   logic access;
   logic wr_mode;
   logic wr_ctrl;
   logic wr_txhold;
   logic wr_status;
   logic wr_div;
   logic rd_status;
   logic mapped;
   logic tick;
   logic tx_start;
   logic te_fall;
   logic tx_end;
   scac_rx_state_t rx_state;
   logic [7:0] rx_shifter;
   logic [3:0] rx_tick_cnt;
   logic [2:0] rx_bit_cnt;
   logic rx_par_acc;
   logic rx_par_bad;
   logic rx_done;
   logic rx_stop_ok;
   logic rx_par_ok;
   logic rx_store;
   logic rx_overrun;

   scac_tx_if tx_link ();

   // ==========================================
   // Helpers
   // Address match for a register index
   function automatic logic reg_hit(input logic [31:0] addr, input logic [23:0] idx);
      reg_hit = (addr == {6'h00, idx, 2'b00});
   endfunction : reg_hit

   // Flag update, a set beats any clear
   function automatic logic next_flag(input logic cur, input logic set, input logic clr);
      next_flag = set ? 1'b1 : (clr ? 1'b0 : cur);
   endfunction : next_flag

   // Software clear: write 0 after the flag was read as 1
   function automatic logic sw_clear(input logic wr, input logic wbit, input logic seen);
      sw_clear = wr & ~wbit & seen;
   endfunction : sw_clear

   // ==========================================
   // APB decode
   assign access = psel & penable;
   assign pready = 1'b1;

   // Decode of the addressed register
   always_comb begin
      if (reg_hit(paddr, `SCAC_IDX_MODE)) begin
         mapped = 1'b1;
      end else if (reg_hit(paddr, `SCAC_IDX_CTRL)) begin
         mapped = 1'b1;
      end else if (reg_hit(paddr, `SCAC_IDX_TXHOLD)) begin
         mapped = 1'b1;
      end else if (reg_hit(paddr, `SCAC_IDX_STATUS)) begin
         mapped = 1'b1;
      end else if (reg_hit(paddr, `SCAC_IDX_RXHOLD)) begin
         mapped = 1'b1;
      end else if (reg_hit(paddr, `SCAC_IDX_DIVISOR)) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   assign pslverr = access & ~mapped;

   // Write strobes in the access phase
   assign wr_mode = access & pwrite & reg_hit(paddr, `SCAC_IDX_MODE);
   assign wr_ctrl = access & pwrite & reg_hit(paddr, `SCAC_IDX_CTRL);
   assign wr_txhold = access & pwrite & reg_hit(paddr, `SCAC_IDX_TXHOLD);
   assign wr_status = access & pwrite & reg_hit(paddr, `SCAC_IDX_STATUS);
   assign wr_div = access & pwrite & reg_hit(paddr, `SCAC_IDX_DIVISOR);
   assign rd_status = access & ~pwrite & reg_hit(paddr, `SCAC_IDX_STATUS);

   // Status image, low two bits read zero
   assign status_value = {tx_buffer_empty, rx_buffer_full, overrun_flag, frame_err_flag,
                          parity_err_flag, tx_end, 2'b00};

   // Read data captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         if (reg_hit(paddr, `SCAC_IDX_MODE)) begin
            prdata <= {24'h00_0000, serial_mode};
         end else if (reg_hit(paddr, `SCAC_IDX_CTRL)) begin
            prdata <= {24'h00_0000, serial_control};
         end else if (reg_hit(paddr, `SCAC_IDX_TXHOLD)) begin
            prdata <= {24'h00_0000, tx_holding_reg};
         end else if (reg_hit(paddr, `SCAC_IDX_STATUS)) begin
            prdata <= {24'h00_0000, status_value};
         end else if (reg_hit(paddr, `SCAC_IDX_RXHOLD)) begin
            prdata <= {24'h00_0000, rx_holding_reg};
         end else if (reg_hit(paddr, `SCAC_IDX_DIVISOR)) begin
            prdata <= {24'h00_0000, divisor};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ==========================================
   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_mode <= `SCAC_MODE_RST;
      end else if (wr_mode) begin
         serial_mode <= pwdata[7:0];
      end
   end

   // Enables and clock select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_control <= `SCAC_CTRL_RST;
      end else if (wr_ctrl) begin
         serial_control <= pwdata[7:0];
      end
   end

   // Internal generator divisor
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divisor <= `SCAC_DIV_RST;
      end else if (wr_div) begin
         divisor <= pwdata[7:0];
      end
   end

   // Holding byte from software or DMA
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_holding_reg <= `SCAC_TXHOLD_RST;
      end else if (dma_tx_write) begin
         tx_holding_reg <= dma_tx_data;
      end else if (wr_txhold) begin
         tx_holding_reg <= pwdata[7:0];
      end
   end

   // ==========================================
   // Bit clock
   scac_baud u_baud (
      .pclk(pclk),
      .presetn(presetn),
      .ext_sel(serial_control[`SCAC_CTRL_CKS_HI]),
      .divisor(divisor),
      .timer_clock_input(timer_clock_input),
      .tick(tick)
   );

   // ==========================================
   // Transmitter
   assign tx_start = serial_control[`SCAC_CTRL_TE] & ~tx_buffer_empty & ~tx_link.busy;
   assign te_fall = wr_ctrl & serial_control[`SCAC_CTRL_TE] & ~pwdata[`SCAC_CTRL_TE];
   assign tx_end = tx_buffer_empty & ~tx_link.busy;

   // Shifter link
   assign tx_link.tick = tick;
   assign tx_link.word_length = serial_mode[`SCAC_MODE_WLEN];
   assign tx_link.parity_on = serial_mode[`SCAC_MODE_PAR];
   assign tx_link.two_stop = serial_mode[`SCAC_MODE_STOP];
   assign tx_link.enable = serial_control[`SCAC_CTRL_TE];
   assign tx_link.load = tx_start;
   assign tx_link.data = tx_holding_reg;
   assign txd = tx_link.line;

   scac_tx u_tx (
      .pclk(pclk),
      .presetn(presetn),
      .tx(tx_link)
   );

   // ==========================================
   // Receiver
   // Sixteen-times sampling, start checked at mid bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state <= SCAC_RX_IDLE;
         rx_shifter <= 8'h00;
         rx_tick_cnt <= 4'h0;
         rx_bit_cnt <= 3'h0;
         rx_par_acc <= 1'b0;
         rx_par_bad <= 1'b0;
      end else if (!serial_control[`SCAC_CTRL_RE]) begin
         rx_state <= SCAC_RX_IDLE;
      end else if (tick) begin
         rx_tick_cnt <= rx_tick_cnt + 4'h1;
         case (rx_state)
            SCAC_RX_IDLE: begin
               rx_tick_cnt <= 4'h0;
               rx_par_acc <= 1'b0;
               rx_par_bad <= 1'b0;
               if (!rxd) begin
                  rx_state <= SCAC_RX_START;
               end
            end
            SCAC_RX_START: begin
               if (rx_tick_cnt == `SCAC_TICK_MID) begin
                  rx_tick_cnt <= 4'h0;
                  rx_bit_cnt <= 3'h0;
                  rx_state <= rxd ? SCAC_RX_IDLE : SCAC_RX_DATA;
               end
            end
            SCAC_RX_DATA: begin
               if (rx_tick_cnt == `SCAC_TICK_LAST) begin
                  rx_shifter <= {rxd, rx_shifter[7:1]};
                  rx_par_acc <= rx_par_acc ^ rxd;
                  rx_bit_cnt <= rx_bit_cnt + 3'h1;
                  if (rx_bit_cnt == scac_last_bit(serial_mode[`SCAC_MODE_WLEN])) begin
                     rx_state <= serial_mode[`SCAC_MODE_PAR] ? SCAC_RX_PARITY : SCAC_RX_STOP;
                  end
               end
            end
            SCAC_RX_PARITY: begin
               if (rx_tick_cnt == `SCAC_TICK_LAST) begin
                  rx_par_bad <= rx_par_acc ^ rxd;
                  rx_state <= SCAC_RX_STOP;
               end
            end
            default: begin
               // Only the first stop bit is sampled, then idle hunts again
               if (rx_tick_cnt == `SCAC_TICK_LAST) begin
                  rx_state <= SCAC_RX_IDLE;
               end
            end
         endcase
      end
   end

   // Completion pulse with the frame checks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_done <= 1'b0;
         rx_stop_ok <= 1'b0;
         rx_par_ok <= 1'b0;
      end else begin
         rx_done <= serial_control[`SCAC_CTRL_RE] & tick & (rx_state == SCAC_RX_STOP)
                    & (rx_tick_cnt == `SCAC_TICK_LAST);
         rx_stop_ok <= rxd;
         rx_par_ok <= ~rx_par_bad;
      end
   end

   assign rx_overrun = rx_done & rx_buffer_full;
   assign rx_store = rx_done & ~rx_buffer_full & rx_stop_ok & rx_par_ok;

   // Received byte, dropped on overrun
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_holding_reg <= 8'h00;
      end else if (rx_store) begin
         rx_holding_reg <= serial_mode[`SCAC_MODE_WLEN] ? {1'b0, rx_shifter[7:1]} : rx_shifter;
      end
   end

   assign rx_holding_data = rx_holding_reg;

   // ==========================================
   // Status flags
   // Read-as-one memory for the clearable flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_one <= 5'h00;
      end else if (rd_status) begin
         seen_one <= prdata[7:3];
      end else if (wr_status) begin
         seen_one <= 5'h00;
      end
   end

   // Transmit holding empty
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_buffer_empty <= 1'b1;
      end else begin
         tx_buffer_empty <= next_flag(tx_buffer_empty, tx_start | te_fall,
            sw_clear(wr_status, pwdata[`SCAC_ST_TX_BUFFER_EMPTY], seen_one[4]) | dma_tx_write);
      end
   end

   // Receive holding full, rx_enable plays no part in clearing it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_buffer_full <= 1'b0;
      end else begin
         rx_buffer_full <= next_flag(rx_buffer_full, rx_store,
            sw_clear(wr_status, pwdata[`SCAC_ST_RX_BUFFER_FULL], seen_one[3]) | dma_rx_read);
      end
   end

   // Overrun
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_flag <= 1'b0;
      end else begin
         overrun_flag <= next_flag(overrun_flag, rx_overrun,
            sw_clear(wr_status, pwdata[`SCAC_ST_OVERRUN_FLAG], seen_one[2]));
      end
   end

   // Framing and parity errors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_err_flag <= 1'b0;
         parity_err_flag <= 1'b0;
      end else begin
         frame_err_flag <= next_flag(frame_err_flag, rx_done & ~rx_buffer_full & ~rx_stop_ok,
            sw_clear(wr_status, pwdata[`SCAC_ST_FER], seen_one[1]));
         parity_err_flag <= next_flag(parity_err_flag, rx_done & ~rx_buffer_full & ~rx_par_ok,
            sw_clear(wr_status, pwdata[`SCAC_ST_PER], seen_one[0]));
      end
   end

   // DMA requests follow the flags, tx_request only while the transmitter is enabled
   assign tx_request = tx_buffer_empty & serial_control[`SCAC_CTRL_TE];
   assign rx_request = rx_buffer_full;
endmodule : scac_top
`default_nettype wire

// ### verilog/scac_tx.sv
`timescale 1ns/10ps
`default_nettype none
`include "scac_defs.svh"
module scac_tx import scac_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   scac_tx_if.shifter tx
);
   scac_tx_state_t state;
   logic [7:0] tx_shifter;
   logic [3:0] tick_cnt;
   logic [2:0] bit_cnt;
   logic parity;

   assign tx.busy = (state != SCAC_TX_IDLE);

   // Frame sequencer, line idles high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SCAC_TX_IDLE;
         tx_shifter <= 8'h00;
         tick_cnt <= 4'h0;
         bit_cnt <= 3'h0;
         parity <= 1'b0;
         tx.line <= 1'b1;
      end else if (!tx.enable) begin
         state <= SCAC_TX_IDLE;
         tx.line <= 1'b1;
      end else if (state == SCAC_TX_IDLE) begin
         if (tx.load) begin
            tx_shifter <= tx.data;
            parity <= tx.word_length ? ^tx.data[6:0] : ^tx.data; // Even parity
            tick_cnt <= 4'h0;
            tx.line <= 1'b0;
            state <= SCAC_TX_START;
         end
      end else if (tx.tick) begin
         if (tick_cnt != `SCAC_TICK_LAST) begin
            tick_cnt <= tick_cnt + 4'h1;
         end else begin
            tick_cnt <= 4'h0;
            case (state)
               SCAC_TX_START: begin
                  bit_cnt <= 3'h0;
                  tx.line <= tx_shifter[0];
                  tx_shifter <= {1'b0, tx_shifter[7:1]};
                  state <= SCAC_TX_DATA;
               end
               SCAC_TX_DATA: begin
                  if (bit_cnt == scac_last_bit(tx.word_length)) begin
                     tx.line <= tx.parity_on ? parity : 1'b1;
                     state <= tx.parity_on ? SCAC_TX_PARITY : SCAC_TX_STOP1;
                  end else begin
                     bit_cnt <= bit_cnt + 3'h1;
                     tx.line <= tx_shifter[0];
                     tx_shifter <= {1'b0, tx_shifter[7:1]};
                  end
               end
               SCAC_TX_PARITY: begin
                  tx.line <= 1'b1;
                  state <= SCAC_TX_STOP1;
               end
               SCAC_TX_STOP1: begin
                  state <= tx.two_stop ? SCAC_TX_STOP2 : SCAC_TX_IDLE;
               end
               default: begin
                  state <= SCAC_TX_IDLE;
               end
            endcase
         end
      end
   end
endmodule : scac_tx
`default_nettype wire

// ### verilog/scac_tx_if.sv
`timescale 1ns/10ps
`default_nettype none
interface scac_tx_if;
   logic tick;
   logic word_length;
   logic parity_on;
   logic two_stop;
   logic enable;
   logic load;
   logic [7:0] data;
   logic busy;
   logic line;
   modport core (output tick, word_length, parity_on, two_stop, enable, load, data, input busy, line);
   modport shifter (input tick, word_length, parity_on, two_stop, enable, load, data, output busy, line);
endinterface : scac_tx_if
`default_nettype wire
